// [include/pio_pkg.sv]
// Constants, register map and carrier types for the programmable I/O port logic.
// Assumes one system clock; the processor register window and pads sit outside.
// Summary of operation
// [R01] Output mux picks data-out, address, peripheral, macrocell
// [R02] Source set by configuration plus control bit
// [R03] Readback returns one source per register read
// [R04] Output enable is array term OR direction
// [R05] Without other uses direction alone sets enable
// [R06] Pin feeds data-in and input macrocell path
// [R07] Macrocell groups and chip-selects limited per port
// [R08] Address on A/B, peripheral on A only
// [R09] Port C pins 0,1,5,6 reserved for JTAG
// [R10] Software activates address and peripheral modes
// [R11] Peripheral mode enabled by control bit 7
// [R12] Direction ignored on macrocell-driven pins
// [R13] Direction 1 is output, 0 is input
// [R14] Direction changes take effect at any time
// [R15] Inputs and outputs mix within one port
// [R16] Data-in reads pin levels at fixed offsets
// [R17] Data-in bits without pins are unreliable
// [R18] Data-out drives pin level, resets to zero
// [R19] Programming status on C3, error on C4
// [R20] Small package lacks port A and D2
// [R21] Direction registers reset to zero
// [R22] Data-out writes ignored on logic-array outputs
// [R23] Inactive enable floats pin, input keeps sampling
package pio_pkg;

  localparam int NPORT = 4;
  localparam int PW    = 8;

  // Register offsets per port, index 0..3 is port A..D
  localparam logic [3:0][7:0] DIN_OFS  = {8'h11, 8'h10, 8'h01, 8'h00};
  localparam logic [3:0][7:0] DOUT_OFS = {8'h13, 8'h12, 8'h05, 8'h04};
  localparam logic [3:0][7:0] DIR_OFS  = {8'h15, 8'h14, 8'h07, 8'h06};
  localparam logic [3:0][7:0] DRV_OFS  = {8'h17, 8'h16, 8'h09, 8'h08};
  localparam logic [3:0][7:0] OEN_OFS  = {8'h1b, 8'h1a, 8'h0d, 8'h0c};
  localparam logic [7:0]      CTRL_A_OFS = 8'h02;
  localparam logic [7:0]      CTRL_B_OFS = 8'h03;
  localparam logic [7:0]      MMC_OFS    = 8'h1e;
  localparam int              PERIPHERAL_IO_ENABLE_BIT = 7;
  localparam logic [7:0]      RST_BYTE   = 8'h00;

  // Which pins exist and which sources may reach them
  localparam logic [3:0][7:0] PRESENT  = {8'h06, 8'h9c, 8'hff, 8'hff};
  localparam logic [3:0][7:0] OMC_OK   = {8'h00, 8'h9c, 8'hff, 8'hff};
  localparam logic [3:0][7:0] CS_OK    = {8'h06, 8'h00, 8'h00, 8'h00};
  localparam logic [3:0][7:0] LATCH_OK = {8'h00, 8'h00, 8'hff, 8'hff};
  localparam logic [3:0][7:0] PIO_OK   = {8'h00, 8'h00, 8'h00, 8'hff};
  localparam logic [3:0][7:0] SMALL_ABSENT = {8'h04, 8'h00, 8'h00, 8'hff};
  localparam int              ISP_STAT_BIT = 3;
  localparam int              ISP_ERR_BIT  = 4;

  // Processor register window request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pio_bus_s;

  // Programmed (non-volatile) configuration of one pin
  typedef struct packed {
    logic pld_out;
    logic latch;
    logic pio;
  } pio_pin_cfg_s;

  // Candidate sources for one pin
  typedef struct packed {
    logic output_macrocell;
    logic addr;
    logic pio;
    logic dout;
    logic dir;
    logic arr_oe;
  } pio_src_s;

endpackage

// [src/pio_sync3.sv]
// Three-stage pin input synchroniser with agreement filter.
// Assumes asynchronous pad inputs and one system clock with enable.
`timescale 1ns/1ps
module pio_sync3 #(
  parameter int W = 8
) (
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  input  wire logic         ce_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } pio_sync_s;

  pio_sync_s st_q;
  pio_sync_s st_d;

  // A change counts only once stages two and three agree
  always_comb begin
    st_d    = st_q;
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < W; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.lvl[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= '0;
    end else if (ce_in) begin
      st_q <= st_d;
    end
  end

  assign level_out = st_q.lvl;
endmodule // pio_sync3

// [src/pio_pin_mux.sv]
// Output source mux and output enable for one port pin.
// Assumes permission bits already folded with the port's fixed capabilities.
`timescale 1ns/1ps
module pio_pin_mux
  import pio_pkg::*;
(
  input  wire pio_pin_cfg_s cfg_in,
  input  wire pio_src_s     src_in,
  input  wire logic         ctrl_in,
  input  wire logic         peripheral_io_enable_in,
  input  wire logic         present_in,
  output logic              drv_out,
  output logic              oe_out
);
  // Macrocell output wins; direction and data-out have no say there
  always_comb begin
    drv_out = src_in.dout;                           // R18
    oe_out  = src_in.arr_oe | src_in.dir;            // R04 R05 R13 R14
    if (cfg_in.pld_out) begin
      drv_out = src_in.output_macrocell;                          // R01 R22
      oe_out  = src_in.arr_oe;                       // R12
    end else if (cfg_in.latch && ctrl_in) begin
      drv_out = src_in.addr;                         // R02 R10
    end else if (cfg_in.pio && peripheral_io_enable_in) begin
      drv_out = src_in.pio;                          // R11
    end
    if (!present_in) begin
      drv_out = 1'b0;
      oe_out  = 1'b0;                                // R09 R20
    end
  end
endmodule // pio_pin_mux

// [src/pio_port_top.sv]
// Programmable I/O port logic: four ports, register window, pin muxing.
// Assumes a processor register strobe interface, logic-array sources on the
// same clock, and pads that resolve pin level from pin_out and pin_oe_out.
`timescale 1ns/1ps
module pio_port_top
  import pio_pkg::*;
#(
  parameter bit SMALL_PKG = 1'b0
) (
  input  wire logic                          sys_clk_in,
  input  wire logic                          rst_in,
  input  wire logic                          ce_in,
  input  wire pio_bus_s                      bus_in,
  output logic      [7:0]                    rdata_out,
  input  wire logic [NPORT-1:0][PW-1:0]      pin_in,
  output logic      [NPORT-1:0][PW-1:0]      pin_out,
  output logic      [NPORT-1:0][PW-1:0]      pin_oe_out,
  output logic      [NPORT-1:0][PW-1:0]      imc_out,
  output logic      [NPORT-1:0][PW-1:0]      drive_sel_out,
  output logic                               peripheral_io_enable_out,
  input  wire pio_pin_cfg_s [NPORT-1:0][PW-1:0] cfg_in,
  input  wire logic [NPORT-1:0][PW-1:0]      array_oe_in,
  input  wire logic [PW-1:0]                 macrocell_group_ab_in,
  input  wire logic [PW-1:0]                 macrocell_group_bc_in,
  input  wire logic [PW-1:0]                 port_b_use_bc_in,
  input  wire logic [PW-1:0]                 ext_chip_select_in,
  input  wire logic [15:0]                   latched_addr_in,
  input  wire logic                          port_b_addr_hi_in,
  input  wire logic [PW-1:0]                 pio_data_in,
  input  wire logic                          isp_status_cfg_in,
  input  wire logic                          isp_status_in,
  input  wire logic                          isp_error_in
);

  // Whole register state of the block
  typedef struct packed {
    logic [NPORT-1:0][PW-1:0] dout;
    logic [NPORT-1:0][PW-1:0] dir;
    logic [NPORT-1:0][PW-1:0] drv;
    logic [PW-1:0]            ctrl_a;
    logic [PW-1:0]            ctrl_b;
    logic [PW-1:0]            mmc;
    logic [7:0]               rdata;
    logic [NPORT-1:0][PW-1:0] pin;
    logic [NPORT-1:0][PW-1:0] oe;
    logic [NPORT-1:0][PW-1:0] input_macrocell;
  } pio_state_s;

  pio_state_s st_q;
  pio_state_s st_d;

  logic [NPORT-1:0][PW-1:0] pin_lvl;
  logic [NPORT-1:0][PW-1:0] mux_drv;
  logic [NPORT-1:0][PW-1:0] mux_oe;
  logic [NPORT-1:0][PW-1:0] usable;
  logic [NPORT-1:0][PW-1:0] ctrl_bits;

  // Pad levels are asynchronous; filter before any use
  pio_sync3 #(
    .W (NPORT*PW)
  ) u_sync (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .async_in   (pin_in),
    .level_out  (pin_lvl)
  );

  // Pins that exist on this package and are not JTAG
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      usable[p] = PRESENT[p];                          // R09
      if (SMALL_PKG) begin
        usable[p] = PRESENT[p] & ~SMALL_ABSENT[p];     // R20
      end
    end
    ctrl_bits    = '0;
    ctrl_bits[0] = st_q.ctrl_a;
    ctrl_bits[1] = st_q.ctrl_b;
  end

  // One mux per pin; capabilities fold into the config per port
  for (genvar p = 0; p < NPORT; p++) begin : g_port
    for (genvar b = 0; b < PW; b++) begin : g_pin
      pio_pin_cfg_s cfg_eff;
      pio_src_s     src;
      logic         omc_src;
      logic         addr_src;

      // Group AB to A/B, group BC to B/C, chip-selects to D only
      always_comb begin
        omc_src = 1'b0;                                // R07
        if (p == 0) begin
          omc_src = macrocell_group_ab_in[b];
        end else if (p == 1) begin
          omc_src = port_b_use_bc_in[b] ? macrocell_group_bc_in[b] : macrocell_group_ab_in[b];
        end else if (p == 2) begin
          omc_src = macrocell_group_bc_in[b];
        end else begin
          omc_src = ext_chip_select_in[b];
        end
        if (p == 2 && isp_status_cfg_in && b == ISP_STAT_BIT) begin
          omc_src = isp_status_in;                     // R19
        end
        if (p == 2 && isp_status_cfg_in && b == ISP_ERR_BIT) begin
          omc_src = isp_error_in;                      // R19
        end
        addr_src = latched_addr_in[b];
        if (p == 1 && port_b_addr_hi_in) begin
          addr_src = latched_addr_in[b+8];
        end
      end

      // Modes a port lacks are masked off whatever was programmed
      always_comb begin
        cfg_eff.pld_out = (cfg_in[p][b].pld_out & (OMC_OK[p][b] | CS_OK[p][b]))
                        | (p == 2 && isp_status_cfg_in && (b == ISP_STAT_BIT || b == ISP_ERR_BIT));
        cfg_eff.latch   = cfg_in[p][b].latch & LATCH_OK[p][b];   // R08
        cfg_eff.pio     = cfg_in[p][b].pio & PIO_OK[p][b];       // R08
        src.output_macrocell    = omc_src;
        src.addr   = addr_src;
        src.pio    = pio_data_in[b];
        src.dout   = st_q.dout[p][b];
        src.dir    = st_q.dir[p][b];                   // R15
        src.arr_oe = array_oe_in[p][b];
      end

      pio_pin_mux u_mux (
        .cfg_in     (cfg_eff),
        .src_in     (src),
        .ctrl_in    (ctrl_bits[p][b]),
        .peripheral_io_enable_in  (st_q.mmc[PERIPHERAL_IO_ENABLE_BIT]),
        .present_in (usable[p][b]),
        .drv_out    (mux_drv[p][b]),
        .oe_out     (mux_oe[p][b])
      );
    end
  end

  // Register writes, readback and registered pad drive
  always_comb begin
    st_d = st_q;
    // Writes; bits behind missing pins simply hold zero
    if (bus_in.wr) begin
      for (int p = 0; p < NPORT; p++) begin
        if (bus_in.addr == DOUT_OFS[p]) begin
          st_d.dout[p] = bus_in.wdata & usable[p];     // R18
        end
        if (bus_in.addr == DIR_OFS[p]) begin
          st_d.dir[p] = bus_in.wdata & usable[p];      // R13 R14
        end
        if (bus_in.addr == DRV_OFS[p]) begin
          st_d.drv[p] = bus_in.wdata & usable[p];
        end
      end
      if (bus_in.addr == CTRL_A_OFS && usable[0] != '0) begin
        st_d.ctrl_a = bus_in.wdata;                    // R10
      end
      if (bus_in.addr == CTRL_B_OFS) begin
        st_d.ctrl_b = bus_in.wdata;                    // R10
      end
      if (bus_in.addr == MMC_OFS) begin
        st_d.mmc = bus_in.wdata;                       // R11
      end
    end
    // Exactly one source reaches the read data per access
    if (bus_in.rd) begin
      st_d.rdata = RST_BYTE;
      for (int p = 0; p < NPORT; p++) begin
        if (bus_in.addr == DIN_OFS[p]) begin
          st_d.rdata = pin_lvl[p] & usable[p];         // R03 R16 R17
        end else if (bus_in.addr == DOUT_OFS[p]) begin
          st_d.rdata = st_q.dout[p];                   // R03
        end else if (bus_in.addr == DIR_OFS[p]) begin
          st_d.rdata = st_q.dir[p];                    // R03
        end else if (bus_in.addr == DRV_OFS[p]) begin
          st_d.rdata = st_q.drv[p];                    // R03
        end else if (bus_in.addr == OEN_OFS[p]) begin
          st_d.rdata = st_q.oe[p];                     // R03
        end
      end
      if (bus_in.addr == CTRL_A_OFS) begin
        st_d.rdata = st_q.ctrl_a;                      // R03
      end else if (bus_in.addr == CTRL_B_OFS) begin
        st_d.rdata = st_q.ctrl_b;
      end else if (bus_in.addr == MMC_OFS) begin
        st_d.rdata = st_q.mmc;
      end
    end
    // Pads see one register stage so every output is a flop
    st_d.pin = mux_drv;
    st_d.oe  = mux_oe;                                 // R23
    st_d.input_macrocell = pin_lvl & usable;                       // R06
  end

  // Direction and data-out come up as zero: all pins float
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= '0;                                      // R21 R18
    end else if (ce_in) begin
      st_q <= st_d;
    end
  end

  assign rdata_out                = st_q.rdata;
  assign pin_out                  = st_q.pin;
  assign pin_oe_out               = st_q.oe;
  assign imc_out                  = st_q.input_macrocell;
  assign drive_sel_out            = st_q.drv;
  assign peripheral_io_enable_out = st_q.mmc[PERIPHERAL_IO_ENABLE_BIT];
endmodule // pio_port_top

// [sim/pio_pin_model.sv]
// External circuitry model on the port pads.
// Assumes the pads see drive value and enable from the port logic.
`timescale 1ns/1ps
module pio_pin_model
  import pio_pkg::*;
(
  input  wire logic                     sys_clk_in,
  input  wire logic [NPORT-1:0][PW-1:0] drv_in,
  input  wire logic [NPORT-1:0][PW-1:0] oe_in,
  input  wire logic [NPORT-1:0][PW-1:0] ext_in,
  input  wire logic [NPORT-1:0][PW-1:0] ext_en_in,
  output logic      [NPORT-1:0][PW-1:0] lvl_out
);
  // Device drive wins; floated pins take the outside level.
  // A pin nobody drives shows the inverse of the held drive value,
  // so a stale level can never pass for a fresh one.
  assign lvl_out = (drv_in & oe_in) | (~oe_in & ((ext_in & ext_en_in) | (~drv_in & ~ext_en_in)));
endmodule // pio_pin_model

// [sim/pio_port_checker.sv]
// Port-level assertions for the programmable I/O port logic.
// Assumes one clock domain and asynchronous active-high reset.
`timescale 1ns/1ps
module pio_port_checker
  import pio_pkg::*;
(
  input  wire logic                            sys_clk_in,
  input  wire logic                            rst_in,
  input  wire pio_bus_s                        bus_in,
  input  wire logic [7:0]                      rdata_out,
  input  wire logic [NPORT-1:0][PW-1:0]        pin_oe_out,
  input  wire logic [NPORT-1:0][PW-1:0]        imc_out,
  input  wire logic                            peripheral_io_enable_out,
  input  wire pio_pin_cfg_s [NPORT-1:0][PW-1:0] cfg_in,
  input  wire logic [NPORT-1:0][PW-1:0]        array_oe_in
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  // Reserved pins never driven nor sampled
  jtag_pins_float_a: assert property ((pin_oe_out[2] & 8'h63) == 8'h00)
    else $error("jtag pin driven");
  absent_d_float_a: assert property ((pin_oe_out[3] & 8'hf9) == 8'h00)
    else $error("absent port d pin driven");
  imc_absent_zero_a: assert property ((imc_out[2] & 8'h63) == 8'h00)
    else $error("absent pin on input path");
  // Array term forces the pad on; direction ignored on logic outputs
  array_oe_on_a: assert property (array_oe_in[1][7] |-> ##[1:2] pin_oe_out[1][7])
    else $error("array enable ignored");
  pld_dir_ignored_a: assert property (cfg_in[0][0].pld_out && (!array_oe_in[0][0]) [*2] |=> !pin_oe_out[0][0])
    else $error("direction drove logic output");
  // Readback selection and peripheral enable write
  mmc_read_a: assert property (bus_in.rd && bus_in.addr == MMC_OFS |=> rdata_out[7] == $past(peripheral_io_enable_out))
    else $error("control bit readback wrong");
  oe_read_a: assert property (bus_in.rd && bus_in.addr == 8'h0d |=> rdata_out == $past(pin_oe_out[1]))
    else $error("enable readback wrong");
  unmapped_zero_a: assert property (bus_in.rd && bus_in.addr == 8'h40 |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!bus_in.rd |=> $stable(rdata_out))
    else $error("read data moved");
  peripheral_io_enable_write_a: assert property (bus_in.wr && bus_in.addr == MMC_OFS |=> peripheral_io_enable_out == $past(bus_in.wdata[7]))
    else $error("peripheral enable not taken");
endmodule // pio_port_checker

bind pio_port_top pio_port_checker u_chk (.sys_clk_in, .rst_in, .bus_in, .rdata_out, .pin_oe_out, .imc_out,
  .peripheral_io_enable_out, .cfg_in, .array_oe_in);

// [sim/programmable_io_port_logic_test.sv]
// Self-checking bench for the programmable I/O port logic.
// Assumes the pin model closes the pad loop and the checker is bound.
`timescale 1ns/1ps
module programmable_io_port_logic_test;
  import pio_pkg::*;
  logic sys_clk_in, rst_in, peripheral_io_enable_out;
  pio_bus_s bus_in;
  logic [7:0] rdata_out;
  logic [NPORT-1:0][PW-1:0] pin_in, pin_out, pin_oe_out, imc_out, drive_sel_out, array_oe_in, ext_val, ext_en;
  pio_pin_cfg_s [NPORT-1:0][PW-1:0] cfg_in;
  logic [PW-1:0] macrocell_group_ab_in, macrocell_group_bc_in, port_b_use_bc_in, ext_chip_select_in, pio_data_in;
  logic [15:0] latched_addr_in;
  logic isp_status_cfg_in, isp_status_in, isp_error_in;
  int error_cnt = 0;
  int checks = 0;

  pio_port_top uut (.sys_clk_in, .rst_in, .ce_in(1'b1), .bus_in, .rdata_out, .pin_in, .pin_out, .pin_oe_out,
    .imc_out, .drive_sel_out, .peripheral_io_enable_out, .cfg_in, .array_oe_in, .macrocell_group_ab_in,
    .macrocell_group_bc_in, .port_b_use_bc_in, .ext_chip_select_in, .latched_addr_in,
    .port_b_addr_hi_in(1'b0), .pio_data_in, .isp_status_cfg_in, .isp_status_in, .isp_error_in);
  pio_pin_model u_ext (.sys_clk_in, .drv_in(pin_out), .oe_in(pin_oe_out), .ext_in(ext_val),
    .ext_en_in(ext_en), .lvl_out(pin_in));

  task automatic summarize();
    if (error_cnt == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Strobes last one cycle; an idle edge separates requests
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    bus_in <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk_in);
    bus_in <= '0;
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge sys_clk_in);
    bus_in <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk_in);
    bus_in <= '0;
    @(negedge sys_clk_in);
    chk(nm, e & m, rdata_out & m);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
  endtask

  task automatic t_reset();
    rd("dout a", DOUT_OFS[0], 8'hff, 8'h00);
    rd("dir b", DIR_OFS[1], 8'hff, 8'h00);
    chk("oe b", 8'h00, pin_oe_out[1]);
  endtask
  task automatic t_array();
    wr(DIR_OFS[1], 8'h01);
    @(posedge sys_clk_in);
    array_oe_in[1] <= 8'h80;
    settle(3);
    chk("array oe b", 8'h81, pin_oe_out[1]);
    @(posedge sys_clk_in);
    array_oe_in[1] <= 8'h00;
    settle(3);
    chk("dir only oe b", 8'h01, pin_oe_out[1]);
  endtask
  task automatic t_mixed();
    wr(DOUT_OFS[1], 8'ha5);
    wr(DIR_OFS[1], 8'h0f);
    wr(DRV_OFS[1], 8'h5a);
    settle(6);
    chk("oe b", 8'h0f, pin_oe_out[1]);
    chk("out b", 8'h05, pin_out[1] & 8'h0f);
    chk("drive b", 8'h5a, drive_sel_out[1]);
    rd("oe reg b", OEN_OFS[1], 8'hff, 8'h0f);
    rd("din b", DIN_OFS[1], 8'hff, 8'h05 | (ext_val[1] & 8'hf0));
    chk("imc b", 8'h05 | (ext_val[1] & 8'hf0), imc_out[1]);
    wr(DIR_OFS[1], 8'hf0);
    settle(6);
    chk("oe b turned", 8'hf0, pin_oe_out[1]);
    rd("din b turned", DIN_OFS[1], 8'hff, 8'ha0 | (ext_val[1] & 8'h0f));
  endtask
  task automatic t_reserved();
    wr(DIR_OFS[2], 8'hff);
    wr(DOUT_OFS[2], 8'hff);
    wr(DIR_OFS[3], 8'hff);
    settle(6);
    chk("oe c", 8'h9c, pin_oe_out[2]);
    chk("oe d", 8'h06, pin_oe_out[3]);
    rd("din c", DIN_OFS[2], 8'h9c, 8'h9c);
  endtask
  task automatic t_sources();
    wr(DIR_OFS[0], 8'h07);
    settle(3);
    chk("pld out a0", 8'h01, pin_out[0] & 8'h01);
    chk("pld oe a0", 8'h06, pin_oe_out[0] & 8'h07);
    chk("dout a1", 8'h00, pin_out[0] & 8'h06);
    wr(CTRL_A_OFS, 8'h02);
    wr(MMC_OFS, 8'h80);
    settle(3);
    chk("addr a1 pio a2", 8'h06, pin_out[0] & 8'h06);
    chk("pio enable", 8'h01, {7'h00, peripheral_io_enable_out});
    rd("mmc", MMC_OFS, 8'h80, 8'h80);
    rd("unmapped", 8'h40, 8'hff, 8'h00);
  endtask
  // Programming status pins, and peripheral mode refused on port C
  task automatic t_isp();
    @(posedge sys_clk_in);
    cfg_in[2][7].pio <= 1'b1;
    isp_status_cfg_in <= 1'b1;
    isp_status_in <= 1'b1;
    settle(3);
    chk("isp c3 c4 c7", 8'h88, pin_out[2] & 8'h98);
    @(posedge sys_clk_in);
    isp_status_in <= 1'b0;
    isp_error_in <= 1'b1;
    settle(3);
    chk("isp err c4", 8'h90, pin_out[2] & 8'h98);
    chk("pio masked c7", 8'h80, pin_out[2] & 8'h80);
  endtask

  // Free-running bench clock
  initial begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end
  // Cut a hang well past the expected run length
  initial begin
    repeat (3000) @(posedge sys_clk_in);
    error_cnt++;
    summarize();
  end
  // Static configuration, then the scenarios
  initial begin
    rst_in = 1'b1;
    bus_in = '0;
    cfg_in = '0;
    cfg_in[0][0].pld_out = 1'b1;
    cfg_in[0][1].latch = 1'b1;
    cfg_in[0][2].pio = 1'b1;
    array_oe_in = '0;
    ext_val = {8'h00, 8'h00, 8'h3c, 8'h00};
    ext_en = {8'hff, 8'h9c, 8'hff, 8'hff};
    macrocell_group_ab_in = 8'h01;
    macrocell_group_bc_in = 8'h00;
    port_b_use_bc_in = 8'h00;
    ext_chip_select_in = 8'h00;
    latched_addr_in = 16'h0002;
    pio_data_in = 8'h04;
    isp_status_cfg_in = 1'b0;
    isp_status_in = 1'b0;
    isp_error_in = 1'b0;
    repeat (20) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_array();
    t_mixed();
    t_reserved();
    t_sources();
    t_isp();
    summarize();
  end
endmodule // programmable_io_port_logic_test
